//--- logic/dl_alu_map.vh
// Constants for the dual 16-bit add/subtract datapath
`ifndef DL_ALU_MAP_VH
`define DL_ALU_MAP_VH

// Datapath widths and split point
`define DL_ACC_W        40
`define DL_LO_W         16
`define DL_HI_W         24
`define DL_HI_LSB       16
`define DL_ACC_MSB      39
`define DL_LO_MSB       15
`define DL_OVF_BIT      15
`define DL_SIGN_BIT     15

// Instruction fields
`define DL_OPC_PREFIX   8'hee
`define DL_F_SRC        7:6
`define DL_F_DST        5:4
`define DL_F_OP         3:1
`define DL_INSTR_BYTES  2'h3

// Operation codes in bits 3:1 of the third byte
`define DL_OP_ADDSUB_L  3'h6
`define DL_OP_SUB_AM    3'h1
`define DL_OP_SUB_TM    3'h3
`define DL_OP_ADDSUB_S  3'h7
`define DL_OP_SUB_MA    3'h2
`define DL_OP_SUB_MT    3'h5

// Saturation limits per lane
`define DL_LO_SAT_POS   16'h7fff
`define DL_LO_SAT_NEG   16'h8000
`define DL_HI_SAT_POS   24'h007fff
`define DL_HI_SAT_NEG   24'hff8000

// Paired-word address step
`define DL_ADDR_STEP    16'h0001

// Accumulator value after reset
`define DL_ACC_RST      40'h00_0000_0000

`endif

//--- logic/dl_lane.v
// One arithmetic lane with overflow detection and saturation
`timescale 1ns/1ns
`default_nettype none

module dl_lane #(
  parameter         W       = 16,
  parameter         OVB     = 15,
  parameter [W-1:0] SAT_POS = {W{1'b0}},
  parameter [W-1:0] SAT_NEG = {W{1'b0}}
) (
  // Operands
  input  wire [W-1:0] a,
  input  wire [W-1:0] b,
  // Control
  input  wire         sub,
  input  wire         cin,
  input  wire         sat_en,
  input  wire         ovf_en,
  // Results
  output wire [W-1:0] res,
  output wire         ovf,
  output wire         carry
);

  wire [W-1:0]   b_eff;
  wire [W:0]     exact;
  wire [OVB+1:0] low_sum;
  wire           ovf_raw;

  // Subtraction is a + ~b + 1, so carry means no borrow
  assign b_eff   = sub ? ~b : b;
  assign exact   = {a[W-1], a} + {b_eff[W-1], b_eff} + {{W{1'b0}}, cin};
  assign low_sum = {1'b0, a[OVB:0]} + {1'b0, b_eff[OVB:0]} + {{(OVB+1){1'b0}}, cin};
  assign carry   = low_sum[OVB+1];

  // Exact result must fit a signed value whose sign sits at OVB
  assign ovf_raw = (|exact[W:OVB]) & ~(&exact[W:OVB]);
  assign ovf     = ovf_en & ovf_raw;
  // Direction comes from the sign of the exact, unwrapped result
  assign res     = (sat_en & ovf) ? (exact[W] ? SAT_NEG : SAT_POS) : exact[W-1:0];

endmodule // dl_lane

`default_nettype wire

//--- logic/dl_alu.v
// Dual 16-bit add/subtract datapath with split 40-bit accumulator lanes
//
// Overview of operation
// RQ1 - Split unit into 16-bit low, 24-bit high
// RQ2 - Single memory word: low raw, high extended
// RQ3 - Temporary register: low raw, high extended
// RQ4 - Paired words: low word low, high extended
// RQ5 - Low word at address plus/minus one by parity
// RQ6 - Either lane overflow sets destination overflow
// RQ7 - Overflow at bits 15 and 31
// RQ8 - Carry from high lane at bit 31
// RQ9 - Saturation mode saturates each overflowed lane
// RQ10 - Limits 7FFF/8000 low, 007FFF/FF8000 high
// RQ11 - Legacy mode: no saturation, high overflow only
// RQ12 - Three bytes, one cycle, no parallel enable
// RQ13 - Add/subtract: high adds, low subtracts
// RQ14 - Four subtract operand orders per lane
// RQ15 - Decode prefix byte and operation field
// RQ16 - Repeatable back to back without restriction
// RQ17 - No carry from bit 15 into 16; outside dual mode the subtract forms carry across
`include "dl_alu_map.vh"
`timescale 1ns/1ns
`default_nettype none

module dl_alu (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Instruction from the decoder
  input  wire        instr_valid,
  input  wire [7:0]  instr_byte0,
  input  wire [7:0]  instr_byte1,
  input  wire [7:0]  instr_byte2,
  input  wire        par_enable_bit,
  // Status mode bits
  input  wire        sign_ext_mode,
  input  wire        arith_saturate_mode,
  input  wire        legacy_compat_mode,
  input  wire        dual_lane_mode_bit,
  // Operand fetch
  input  wire [15:0] op_addr,
  output wire [15:0] msw_addr,
  output wire [15:0] lsw_addr,
  input  wire [15:0] msw_data,
  input  wire [15:0] lsw_data,
  output wire [1:0]  src_sel,
  input  wire [15:0] tmp_reg_data,
  input  wire [39:0] src_accumulator,
  // Decode status
  output wire        instr_hit,
  output wire [1:0]  instr_size,
  // Result
  output reg         res_valid_r,
  output reg  [1:0]  res_dst_sel_r,
  output reg  [39:0] dst_accumulator,
  output reg         dest_acc_overflow_flag,
  output reg         carry_flag,
  output reg         instr_reject_r
);

  // Decode
  wire [2:0] op_code;
  wire       prefix_ok;
  reg        op_known;
  wire       take;
  wire       reject;

  // Third byte: source select, destination select, operation, spare bit
  assign op_code   = instr_byte2[`DL_F_OP];
  assign prefix_ok = (instr_byte0 == `DL_OPC_PREFIX); // RQ15
  assign src_sel   = instr_byte2[`DL_F_SRC];

  always @*
  begin
    case (op_code) // RQ15
      `DL_OP_ADDSUB_L: op_known = 1'b1;
      `DL_OP_SUB_AM:   op_known = 1'b1;
      `DL_OP_SUB_TM:   op_known = 1'b1;
      `DL_OP_ADDSUB_S: op_known = 1'b1;
      `DL_OP_SUB_MA:   op_known = 1'b1;
      `DL_OP_SUB_MT:   op_known = 1'b1;
      default:         op_known = 1'b0;
    endcase
  end

  // These forms cannot be paired, so a set parallel-enable bit is refused
  assign instr_hit  = prefix_ok & op_known;
  assign instr_size = instr_hit ? `DL_INSTR_BYTES : 2'h0; // RQ12
  // No busy state: a repeat loop may issue one of these every cycle
  assign take       = instr_valid & instr_hit & ~par_enable_bit; // RQ16
  assign reject     = instr_valid & ~take;

  // Paired word alignment: high word always at the given address
  assign msw_addr = op_addr; // RQ5
  // Only bit 0 picks the step, so the pair never leaves its aligned couple
  assign lsw_addr = op_addr[0] ? (op_addr - `DL_ADDR_STEP)
                               : (op_addr + `DL_ADDR_STEP); // RQ5

  // Operand preparation
  wire [7:0]  msw_ext_bits;
  wire [7:0]  tmp_ext_bits;
  wire [23:0] msw_hi;
  wire [23:0] tmp_hi;
  wire [23:0] acc_hi;
  wire [15:0] acc_lo;

  // With extension off the high lane sees words as unsigned, so it may
  // overflow where the low lane does not
  assign msw_ext_bits = {8{sign_ext_mode & msw_data[`DL_SIGN_BIT]}};
  assign tmp_ext_bits = {8{sign_ext_mode & tmp_reg_data[`DL_SIGN_BIT]}};
  assign msw_hi       = {msw_ext_bits, msw_data};     // RQ2 RQ4
  assign tmp_hi       = {tmp_ext_bits, tmp_reg_data}; // RQ3
  // Guard bits ride with the high lane
  assign acc_hi       = src_accumulator[`DL_ACC_MSB:`DL_HI_LSB]; // RQ1
  assign acc_lo       = src_accumulator[`DL_LO_MSB:0];           // RQ1

  reg [23:0] hi_a;
  reg [23:0] hi_b;
  reg        hi_sub;
  reg [15:0] lo_a;
  reg [15:0] lo_b;
  reg        lo_sub;
  reg        same_op;

  always @*
  begin
    hi_a    = msw_hi;
    hi_b    = tmp_hi;
    hi_sub  = 1'b0;
    lo_a    = lsw_data;
    lo_b    = tmp_reg_data;
    lo_sub  = 1'b1;
    same_op = 1'b0;
    case (op_code)
      `DL_OP_ADDSUB_S:
      begin
        // Single word feeds both lanes
        hi_a = msw_hi;       // RQ2
        hi_b = tmp_hi;       // RQ13
        lo_a = msw_data;     // RQ2
        lo_b = tmp_reg_data; // RQ3
      end
      `DL_OP_ADDSUB_L:
      begin
        hi_a = msw_hi;       // RQ4
        hi_b = tmp_hi;       // RQ13
        lo_a = lsw_data;     // RQ4
        lo_b = tmp_reg_data; // RQ13
      end
      `DL_OP_SUB_AM:
      begin
        hi_a    = acc_hi; // RQ14
        hi_b    = msw_hi;
        hi_sub  = 1'b1;
        lo_a    = acc_lo;
        lo_b    = lsw_data;
        same_op = 1'b1;
      end
      `DL_OP_SUB_MA:
      begin
        hi_a    = msw_hi; // RQ14
        hi_b    = acc_hi;
        hi_sub  = 1'b1;
        lo_a    = lsw_data;
        lo_b    = acc_lo;
        same_op = 1'b1;
      end
      `DL_OP_SUB_TM:
      begin
        hi_a    = tmp_hi; // RQ14
        hi_b    = msw_hi;
        hi_sub  = 1'b1;
        lo_a    = tmp_reg_data;
        lo_b    = lsw_data;
        same_op = 1'b1;
      end
      `DL_OP_SUB_MT:
      begin
        hi_a    = msw_hi; // RQ14
        hi_b    = tmp_hi;
        hi_sub  = 1'b1;
        lo_a    = lsw_data;
        lo_b    = tmp_reg_data;
        same_op = 1'b1;
      end
      default:
      begin
        hi_a    = msw_hi;
        hi_b    = tmp_hi;
        hi_sub  = 1'b0;
        lo_a    = lsw_data;
        lo_b    = tmp_reg_data;
        lo_sub  = 1'b1;
        same_op = 1'b0;
      end
    endcase
  end

  // Mode handling
  wire chain;
  wire sat_en;
  wire lo_ovf_en;
  wire hi_cin;

  // Outside dual mode the same-operation forms act as one 40-bit unit;
  // mixed add/subtract has no meaningful chained form and stays split.
  assign chain     = ~dual_lane_mode_bit & same_op;
  // Legacy mode acts as if saturation were off, and hides low overflow
  assign sat_en    = arith_saturate_mode & ~legacy_compat_mode; // RQ9 RQ11
  assign lo_ovf_en = ~legacy_compat_mode & ~chain;              // RQ11
  // Limitation: a chained result keeps its raw low half even when the
  // high half saturates, since only bit 31 is checked there

  // Lanes
  // Both lanes check bit 15 of their own sum, which for the high lane
  // is bit 31 of the accumulator
  wire [15:0] lo_res;
  wire        lo_ovf;
  wire        lo_carry;
  wire [23:0] hi_res;
  wire        hi_ovf;
  wire        hi_carry;

  dl_lane #(
    .W       (`DL_LO_W),
    .OVB     (`DL_OVF_BIT),
    .SAT_POS (`DL_LO_SAT_POS),
    .SAT_NEG (`DL_LO_SAT_NEG)
  ) u_lo_lane (
    .a      (lo_a),
    .b      (lo_b),
    .sub    (lo_sub),
    .cin    (lo_sub),
    .sat_en (sat_en),    // RQ9 RQ10
    .ovf_en (lo_ovf_en), // RQ7
    .res    (lo_res),
    .ovf    (lo_ovf),
    .carry  (lo_carry)
  );

  // Dual mode blocks the low lane carry from the high lane
  assign hi_cin = chain ? lo_carry : hi_sub; // RQ17

  dl_lane #(
    .W       (`DL_HI_W),
    .OVB     (`DL_OVF_BIT),
    .SAT_POS (`DL_HI_SAT_POS),
    .SAT_NEG (`DL_HI_SAT_NEG)
  ) u_hi_lane (
    .a      (hi_a),
    .b      (hi_b),
    .sub    (hi_sub),
    .cin    (hi_cin),
    .sat_en (sat_en), // RQ9 RQ10
    .ovf_en (1'b1),   // RQ7
    .res    (hi_res),
    .ovf    (hi_ovf),
    .carry  (hi_carry)
  );

  // Result registers
  wire [39:0] acc_nxt;
  wire        ovf_nxt;

  assign acc_nxt = {hi_res, lo_res};   // RQ1
  assign ovf_nxt = lo_ovf | hi_ovf;    // RQ6

  // One-cycle status pulses, fresh on every edge so that a repeat loop
  // sees one pulse per accepted instruction
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      res_valid_r            <= 1'b0;
      instr_reject_r         <= 1'b0;
      dest_acc_overflow_flag <= 1'b0;
    end
    else
    begin
      res_valid_r            <= take;           // RQ12
      instr_reject_r         <= reject;         // RQ15
      dest_acc_overflow_flag <= take & ovf_nxt; // RQ6
    end
  end

  // Held result: a refused instruction leaves the accumulator untouched
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      res_dst_sel_r   <= 2'h0;
      dst_accumulator <= `DL_ACC_RST;
      carry_flag      <= 1'b0;
    end
    else if (take)
    begin
      res_dst_sel_r   <= instr_byte2[`DL_F_DST];
      dst_accumulator <= acc_nxt;  // RQ1
      carry_flag      <= hi_carry; // RQ8
    end
  end

endmodule // dl_alu

`default_nettype wire

//--- sim/dl_alu_checker.sv
// Concurrent checks on the ports of the dual-lane datapath
`timescale 1ns/1ns
`default_nettype none

module dl_alu_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Instruction
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_byte0,
  input wire logic        par_enable_bit,
  input wire logic [15:0] op_addr,
  // Decode and fetch
  input wire logic [15:0] msw_addr,
  input wire logic [15:0] lsw_addr,
  input wire logic        instr_hit,
  input wire logic [1:0]  instr_size,
  // Result
  input wire logic        res_valid_r,
  input wire logic        dest_acc_overflow_flag,
  input wire logic        instr_reject_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    instr_valid && instr_hit && !par_enable_bit;
  endsequence

  a_msw_addr_same: assert property (msw_addr == op_addr) else $error("msw address");
  a_lsw_addr_parity: assert property (lsw_addr == (op_addr ^ 16'h0001))
    else $error("lsw address");
  a_take_one_cycle: assert property (s_take |=> res_valid_r && !instr_reject_r)
    else $error("no result one cycle after take");
  a_parallel_refused: assert property (instr_valid && par_enable_bit |=> instr_reject_r)
    else $error("parallel form not refused");
  a_unknown_refused: assert property (instr_valid && !instr_hit |=> !res_valid_r)
    else $error("unknown form gave result");
  a_prefix_needed: assert property (instr_byte0 != 8'hee |-> !instr_hit)
    else $error("hit without prefix");
  a_size_three: assert property (instr_size == (instr_hit ? 2'h3 : 2'h0))
    else $error("size wrong");
  a_repeat_b2b: assert property (s_take ##1 s_take |-> res_valid_r ##1 res_valid_r)
    else $error("back to back lost");
  a_ovf_with_result: assert property (dest_acc_overflow_flag |-> res_valid_r)
    else $error("overflow without result");
endmodule // dl_alu_checker

bind dl_alu dl_alu_checker u_chk (.core_clk, .rst, .instr_valid, .instr_byte0,
  .par_enable_bit, .op_addr, .msw_addr, .lsw_addr, .instr_hit, .instr_size,
  .res_valid_r, .dest_acc_overflow_flag, .instr_reject_r);

`default_nettype wire

//--- sim/dl_fetch_model.sv
// Operand fetch partner: data memory, temporary registers, accumulators
`timescale 1ns/1ns
`default_nettype none

module dl_fetch_model (
  // From the datapath
  input  wire logic [15:0] msw_addr,
  input  wire logic [15:0] lsw_addr,
  input  wire logic [1:0]  src_sel,
  // Operands
  output logic      [15:0] msw_data,
  output logic      [15:0] lsw_data,
  output logic      [15:0] tmp_reg_data,
  output logic      [39:0] src_accumulator
);
  // Low address byte only, so memory aliases every 256 words
  logic [15:0] mem [0:255];
  logic [15:0] tmp [0:3];
  logic [39:0] acc [0:3];

  assign msw_data        = mem[msw_addr[7:0]];
  assign lsw_data        = mem[lsw_addr[7:0]];
  assign tmp_reg_data    = tmp[src_sel];
  assign src_accumulator = acc[src_sel];
endmodule // dl_fetch_model

`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the dual-lane add/subtract datapath
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        core_clk, rst, instr_valid, par_enable_bit, dual_lane_mode_bit;
  logic        sign_ext_mode, arith_saturate_mode, legacy_compat_mode;
  logic [7:0]  instr_byte0, instr_byte1, instr_byte2;
  logic [15:0] op_addr, msw_addr, lsw_addr, msw_data, lsw_data, tmp_reg_data;
  logic [1:0]  src_sel, instr_size, res_dst_sel_r;
  logic [39:0] src_accumulator, dst_accumulator, last_acc;
  logic        instr_hit, res_valid_r, dest_acc_overflow_flag, carry_flag, instr_reject_r;
  logic        last_c;
  logic [45:0] expq [$];
  int          errors, cmp_count, cycles;

  dl_alu DUT (.core_clk, .rst, .instr_valid, .instr_byte0, .instr_byte1, .instr_byte2,
    .par_enable_bit, .sign_ext_mode, .arith_saturate_mode, .legacy_compat_mode,
    .dual_lane_mode_bit, .op_addr, .msw_addr, .lsw_addr, .msw_data, .lsw_data, .src_sel,
    .tmp_reg_data, .src_accumulator, .instr_hit, .instr_size, .res_valid_r, .res_dst_sel_r,
    .dst_accumulator, .dest_acc_overflow_flag, .carry_flag, .instr_reject_r);
  dl_fetch_model u_mem (.msw_addr, .lsw_addr, .src_sel, .msw_data, .lsw_data,
    .tmp_reg_data, .src_accumulator);

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (e !== g)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Boundary words are favoured so that both lanes overflow often
  function automatic logic [15:0] pick();
    logic [63:0] tbl;
    tbl = 64'h7fff_8000_ffff_0001;
    return ($urandom % 2) ? tbl[16 * ($urandom % 4) +: 16] : 16'($urandom);
  endfunction

  function automatic int ext(input logic [15:0] v, input logic sx);
    return sx ? int'($signed(v)) : int'(v);
  endfunction

  // Returns {overflow, carry, high lane, low lane}
  // Outside dual mode the subtract forms borrow across bit 15 as one unit
  function automatic logic [41:0] model(input logic [2:0] op, input logic [15:0] m, l, t,
                                        input logic [39:0] a, input logic sx, sat, leg, dl);
    int   ha, hb, la, lb, he, le, bw;
    logic add, hov, lov, ch;
    add = (op[2:1] == 2'b11);
    ch = !dl && !add;
    ha = ext(m, sx);
    la = $signed(op == 3'h7 ? m : l);
    hb = op[2:1] == 2'b00 || op == 3'h2 ? int'($signed(a[39:16])) : ext(t, sx);
    lb = $signed(op == 3'h1 || op == 3'h2 ? a[15:0] : t);
    if (op == 3'h1 || op == 3'h3)
    begin
      {ha, hb} = {hb, ha};
      {la, lb} = {lb, la};
    end
    bw = (ch && (la & 65535) < (lb & 65535)) ? 1 : 0;
    he = add ? ha + hb : ha - hb - bw;
    le = la - lb;
    hov = he > 32767 || he < -32768;
    lov = !leg && !ch && (le > 32767 || le < -32768);
    return {hov | lov,
            add ? (ha & 65535) + (hb & 65535) > 65535 : (ha & 65535) >= (hb & 65535) + bw,
            (hov && sat && !leg) ? (he < 0 ? 24'hff8000 : 24'h007fff) : he[23:0],
            (lov && sat) ? (le < 0 ? 16'h8000 : 16'h7fff) : le[15:0]};
  endfunction

  task automatic check_one(input logic [45:0] e);
    chk("result valid", 40'(e[45]), 40'(res_valid_r));
    chk("reject", 40'(e[44]), 40'(instr_reject_r));
    chk("overflow", 40'(e[45] & e[41]), 40'(dest_acc_overflow_flag));
    if (e[45])
    begin
      last_acc = e[39:0];
      last_c = e[40];
      chk("dest select", 40'(e[43:42]), 40'(res_dst_sel_r));
    end
    chk("accumulator", last_acc, dst_accumulator);
    chk("carry", 40'(last_c), 40'(carry_flag));
  endtask

  initial
  begin
    logic [2:0]  op, md;
    logic [7:0]  b0, b2;
    logic [15:0] adr;
    logic        iv, pe, ok, dl;
    void'($urandom(32'hed1c8c05));
    {rst, instr_valid, par_enable_bit, dual_lane_mode_bit} = 4'b1001;
    {sign_ext_mode, arith_saturate_mode, legacy_compat_mode} = 3'h0;
    {instr_byte0, instr_byte1, instr_byte2, op_addr} = 40'h0;
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = pick();
    for (int i = 0; i < 4; i++)
    begin
      u_mem.tmp[i] = pick();
      u_mem.acc[i] = {($urandom % 2) ? 8'hff : 8'h00, pick(), pick()};
    end
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    {last_acc, last_c} = 41'h0;
    check_one(46'h0);
    $display("Test reset done");
    for (int n = 0; n < 600; n++)
    begin
      @(posedge core_clk);
      if (expq.size() == 2)
        check_one(expq.pop_front());
      op = 3'($urandom);
      md = 3'($urandom);
      dl = ($urandom % 4 != 0);
      adr = 16'($urandom);
      b0 = ($urandom % 12 == 0) ? 8'($urandom) : 8'hee;
      b2 = {4'($urandom), op, 1'($urandom)};
      pe = ($urandom % 12 == 0);
      iv = ($urandom % 6 != 0);
      instr_valid <= iv;
      instr_byte0 <= b0;
      instr_byte1 <= 8'($urandom);
      instr_byte2 <= b2;
      par_enable_bit <= pe;
      op_addr <= adr;
      {sign_ext_mode, arith_saturate_mode, legacy_compat_mode} <= md;
      dual_lane_mode_bit <= dl;
      ok = iv && b0 == 8'hee && !(op inside {3'h0, 3'h4}) && !pe;
      expq.push_back({ok, iv && !ok, b2[5:4], model(op, u_mem.mem[adr[7:0]],
        u_mem.mem[adr[7:0] ^ 8'h01], u_mem.tmp[b2[7:6]], u_mem.acc[b2[7:6]],
        md[2], md[1], md[0], dl)});
    end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    check_one(expq.pop_front());
    @(posedge core_clk);
    check_one(expq.pop_front());
    $display("Test random operations done");
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
